// ==== verilog/led_pulse_pwm_control.sv ====
// Top of the single LED channel: APB registers, pulse and PWM control.
// Assumes an APB master, a synchronous trigger input and one 125 MHz clock.
//
// Summary of operation
// - an output-bit rising edge fires one pulse while the sequencer is idle
// - pulse time in 1 us, or 100 ns
// - hardware enable gates pulses by trigger input
// - PWM duty above power limit is ignored
// - PWM runs at 1050 Hz until reconfigured
// - currents in mA, voltages in 0.01 V
// - operation mode register selects behaviour
// - cyclic set current only with current mapping
// - delay is cyclic delay plus fixed delay
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ps
module led_pulse_pwm_control #(
    parameter int PWM_DEFAULT_HZ = led_pkg::PWM_DEFAULT_HZ
) (
    // Clock, reset and enable.
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Trigger input.
    input  wire logic        trig_in,
    // LED drive stage.
    output logic             led_drive,
    output logic [15:0]      led_current_ma,
    output logic [15:0]      led_voltage_cv
);
    logic [1:0]  control_reg;
    logic [15:0] set_current_reg;
    logic [15:0] pulse_length_reg;
    logic [15:0] pulse_delay_reg;
    logic [14:0] duty_reg;
    logic [15:0] target_reg;
    logic [15:0] supply_reg;
    logic [15:0] outvolt_reg;
    logic [15:0] fixdelay_reg;
    logic [3:0]  mode_reg;
    logic [2:0]  config_reg;
    logic [15:0] freq_reg;
    logic [14:0] limit_reg;
    logic        out_prev_reg;
    logic [26:0] acc_reg;
    logic [26:0] thr_reg;

    // Bus decode.
    wire         bus_take  = psel && penable && pready;
    wire         wr        = bus_take && pwrite;
    wire         sel_ctrl  = paddr == led_pkg::OFS_CONTROL;
    wire         sel_stat  = paddr == led_pkg::OFS_STATUS;
    wire         sel_cur   = paddr == led_pkg::OFS_CURRENT;
    wire         sel_len   = paddr == led_pkg::OFS_LENGTH;
    wire         sel_dly   = paddr == led_pkg::OFS_DELAY;
    wire         sel_duty  = paddr == led_pkg::OFS_DUTY;
    wire         sel_tgt   = paddr == led_pkg::OFS_TARGET;
    wire         sel_sup   = paddr == led_pkg::OFS_SUPPLY;
    wire         sel_ov    = paddr == led_pkg::OFS_OUTVOLT;
    wire         sel_fix   = paddr == led_pkg::OFS_FIXDELAY;
    wire         sel_mode  = paddr == led_pkg::OFS_MODE;
    wire         sel_cfg   = paddr == led_pkg::OFS_CONFIG;
    wire         sel_freq  = paddr == led_pkg::OFS_FREQ;
    wire         sel_lim   = paddr == led_pkg::OFS_LIMIT;
    wire         mapped    = sel_ctrl | sel_stat | sel_cur | sel_len |
                             sel_dly | sel_duty | sel_tgt | sel_sup |
                             sel_ov | sel_fix | sel_mode | sel_cfg |
                             sel_freq | sel_lim;

    // Channel state.
    wire         mode_plc  = mode_reg == led_pkg::MODE_PLC_PULSE;
    wire         mode_pwm  = mode_reg == led_pkg::MODE_PWM;
    wire         div_busy;
    wire         div_done;
    wire [25:0]  div_quot;
    wire         seq_busy;
    wire         seq_pulse;
    wire         ready     = (mode_plc || mode_pwm) && !div_busy;
    wire         fine_res  = config_reg[led_pkg::CFG_FINE_BIT];
    wire         hw_enable = config_reg[led_pkg::CFG_HWEN_BIT];
    wire         cur_map   = config_reg[led_pkg::CFG_MAP_BIT];
    wire         enable    = control_reg[led_pkg::CTRL_ENABLE_BIT];
    wire         out_bit   = control_reg[led_pkg::CTRL_OUTPUT_BIT];
    wire         hw_ok     = !hw_enable || trig_in;
    wire         out_rise  = out_bit && !out_prev_reg;
    wire         fire      = mode_plc && enable && ready && hw_ok &&
                             out_rise;
    wire         duty_ok   = pwdata[14:0] <= limit_reg &&
                             pwdata[31:15] == 17'h00000;
    wire [14:0]  limit_new = (div_quot > 26'(led_pkg::DUTY_FULL)) ?
                             15'(led_pkg::DUTY_FULL) : div_quot[14:0];
    wire [41:0]  thr_prod  = {27'h0000000, duty_reg} *
                             42'(led_pkg::CLK_HZ);
    wire [27:0]  acc_sum   = {1'b0, acc_reg} + {12'h000, freq_reg};
    wire         acc_wrap  = acc_sum >= 28'(led_pkg::CLK_HZ);
    wire [26:0]  acc_next  = acc_wrap ?
                             27'(acc_sum - 28'(led_pkg::CLK_HZ)) :
                             acc_sum[26:0];
    wire         pwm_on    = acc_reg < thr_reg;
    wire         drive_next = mode_plc ? seq_pulse :
                             (mode_pwm && enable && out_bit && ready &&
                              hw_ok && pwm_on);
    wire [15:0]  cur_next  = (mode_pwm && !cur_map) ? target_reg :
                             set_current_reg;

    // Delay terms in fine ticks or in the selected unit.
    wire [15:0]  fix_ticks = fixdelay_reg;
    wire [31:0]  status_w  = {28'h0000000, seq_busy, led_drive, div_busy,
                              ready};
    wire [31:0]  rd_mux    =
        sel_ctrl ? {30'h00000000, control_reg} :
        sel_stat ? status_w :
        sel_cur  ? {16'h0000, set_current_reg} :
        sel_len  ? {16'h0000, pulse_length_reg} :
        sel_dly  ? {16'h0000, pulse_delay_reg} :
        sel_duty ? {17'h00000, duty_reg} :
        sel_tgt  ? {16'h0000, target_reg} :
        sel_sup  ? {16'h0000, supply_reg} :
        sel_ov   ? {16'h0000, outvolt_reg} :
        sel_fix  ? {16'h0000, fixdelay_reg} :
        sel_mode ? {28'h0000000, mode_reg} :
        sel_cfg  ? {29'h00000000, config_reg} :
        sel_freq ? {16'h0000, freq_reg} :
        sel_lim  ? {17'h00000, limit_reg} : 32'h00000000;

    duty_limit_divider #(
        .NW       (26),
        .DW       (16)
    ) u_div (
        .clk      (clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .start    (wr && sel_tgt),
        .dividend (led_pkg::LIMIT_NUM),
        .divisor  (pwdata[15:0]),
        .busy     (div_busy),
        .done     (div_done),
        .quotient (div_quot)
    );

    pulse_sequencer u_seq (
        .clk          (clk),
        .rst_n        (rst_n),
        .ce           (ce),
        .fire         (fire),
        .fine_res     (fine_res),
        .fixed_ticks  (fix_ticks),
        .delay_ticks  (pulse_delay_reg),
        .length_ticks (pulse_length_reg),
        .busy         (seq_busy),
        .pulse_on     (seq_pulse)
    );

    // APB answer: one wait cycle, then data and error from flip-flops.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else if (ce)
        begin
            pready  <= psel && penable && !pready;
            prdata  <= (!pwrite && mapped) ? rd_mux : 32'h00000000;
            pslverr <= !mapped;
        end
    end

    // Software-written configuration.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            control_reg      <= 2'h0;
            set_current_reg  <= 16'h0000;
            pulse_length_reg <= 16'h0000;
            pulse_delay_reg  <= 16'h0000;
            target_reg       <= 16'h0000;
            supply_reg       <= 16'h0000;
            outvolt_reg      <= 16'h0000;
            fixdelay_reg     <= 16'h0000;
            mode_reg         <= led_pkg::MODE_OFF;
            config_reg       <= 3'h0;
            freq_reg         <= 16'(PWM_DEFAULT_HZ);
        end
        else if (ce && wr)
        begin
            if (sel_ctrl) control_reg      <= pwdata[1:0];
            if (sel_cur)  set_current_reg  <= pwdata[15:0];
            if (sel_len)  pulse_length_reg <= pwdata[15:0];
            if (sel_dly)  pulse_delay_reg  <= pwdata[15:0];
            if (sel_tgt)  target_reg       <= pwdata[15:0];
            if (sel_sup)  supply_reg       <= pwdata[15:0];
            if (sel_ov)   outvolt_reg      <= pwdata[15:0];
            if (sel_fix)  fixdelay_reg     <= pwdata[15:0];
            if (sel_mode) mode_reg         <= pwdata[3:0];
            if (sel_cfg)  config_reg       <= pwdata[2:0];
            if (sel_freq) freq_reg         <= pwdata[15:0];
        end
    end

    // Duty acceptance, limit and PWM engine.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            duty_reg  <= 15'h0000;
            limit_reg <= 15'(led_pkg::DUTY_FULL);
            acc_reg   <= 27'h0000000;
            thr_reg   <= 27'h0000000;
        end
        else if (ce)
        begin
            if (wr && sel_duty && duty_ok)
                duty_reg <= pwdata[14:0];
            if (div_done)
                limit_reg <= limit_new;
            acc_reg <= acc_next;
            thr_reg <= thr_prod[41:led_pkg::DUTY_SHIFT];
        end
    end

    // Edge memory and registered drive outputs.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_prev_reg   <= 1'b0;
            led_drive      <= 1'b0;
            led_current_ma <= 16'h0000;
            led_voltage_cv <= 16'h0000;
        end
        else if (ce)
        begin
            out_prev_reg   <= out_bit;
            led_drive      <= drive_next;
            led_current_ma <= cur_next;
            led_voltage_cv <= outvolt_reg;
        end
    end

    sequence s_fire;
        fire ##1 seq_busy;
    endsequence

    property p_pulse_fire;
        @(posedge clk) disable iff (!rst_n)
        (fire && ce) |-> s_fire;
    endproperty
    a_pulse_fire: assert property (p_pulse_fire)
        else $error("Pulse did not start.");

    property p_one_per_edge;
        @(posedge clk) disable iff (!rst_n)
        (out_bit && $past(out_bit) && $past(ce)) |-> !fire;
    endproperty
    a_one_per_edge: assert property (p_one_per_edge)
        else $error("Held output bit fired again.");

    property p_hw_enable;
        @(posedge clk) disable iff (!rst_n)
        (fire && hw_enable) |-> trig_in;
    endproperty
    a_hw_enable: assert property (p_hw_enable)
        else $error("Pulse fired without trigger enable.");

    property p_duty_reject;
        @(posedge clk) disable iff (!rst_n)
        (ce && wr && sel_duty && pwdata[14:0] > limit_reg)
            |=> $stable(duty_reg);
    endproperty
    a_duty_reject: assert property (p_duty_reject)
        else $error("Rejected duty was adopted.");

    property p_duty_accept;
        @(posedge clk) disable iff (!rst_n)
        (ce && wr && sel_duty && duty_ok)
            |=> duty_reg == $past(pwdata[14:0]);
    endproperty
    a_duty_accept: assert property (p_duty_accept)
        else $error("Accepted duty not stored.");

    property p_freq_hold;
        @(posedge clk) disable iff (!rst_n)
        !(wr && sel_freq) |=> $stable(freq_reg);
    endproperty
    a_freq_hold: assert property (p_freq_hold)
        else $error("PWM frequency changed without write.");

    property p_mode_off;
        @(posedge clk) disable iff (!rst_n)
        (ce && !mode_plc && !mode_pwm) |=> !led_drive;
    endproperty
    a_mode_off: assert property (p_mode_off)
        else $error("LED driven outside a supported mode.");

    property p_current_map;
        @(posedge clk) disable iff (!rst_n)
        (ce && mode_pwm && !cur_map) |=> led_current_ma == $past(target_reg);
    endproperty
    a_current_map: assert property (p_current_map)
        else $error("Cyclic set current used without mapping.");

endmodule : led_pulse_pwm_control

// ==== verilog/led_pkg.sv ====
// Shared constants, register map and state types of the LED pulse and PWM
// channel.
// Assumes a 125 MHz system clock and a 32-bit APB register bus.
package led_pkg;

    // Clock and time base.
    localparam int CLK_HZ      = 125_000_000;
    localparam int CLK_MHZ     = 125;
    localparam int US_NS       = 1000;
    localparam int FINE_NS     = 100;
    localparam int US_CYC      = (US_NS * CLK_MHZ + 999) / 1000;
    localparam int FINE_CYC    = (FINE_NS * CLK_MHZ + 999) / 1000;
    localparam int FINE_PER_US = US_NS / FINE_NS;

    // PWM base frequency after reset, in Hz.
    localparam int PWM_DEFAULT_HZ = 1050;

    // Duty-cycle scale and power limit of the PWM current mode.
    localparam int     DUTY_FULL     = 32767;
    localparam int     DUTY_SHIFT    = 15;
    localparam longint LIMIT_PWR_MW  = 600;
    localparam longint LIMIT_DROP_MV = 500;
    localparam longint LIMIT_NUM_L   =
        longint'(DUTY_FULL) * LIMIT_PWR_MW * 1000 / LIMIT_DROP_MV;
    localparam logic [25:0] LIMIT_NUM = 26'(LIMIT_NUM_L);

    // Register byte offsets.
    localparam logic [7:0] OFS_CONTROL  = 8'h00;
    localparam logic [7:0] OFS_STATUS   = 8'h04;
    localparam logic [7:0] OFS_CURRENT  = 8'h08;
    localparam logic [7:0] OFS_LENGTH   = 8'h0c;
    localparam logic [7:0] OFS_DELAY    = 8'h10;
    localparam logic [7:0] OFS_DUTY     = 8'h14;
    localparam logic [7:0] OFS_TARGET   = 8'h18;
    localparam logic [7:0] OFS_SUPPLY   = 8'h1c;
    localparam logic [7:0] OFS_OUTVOLT  = 8'h20;
    localparam logic [7:0] OFS_FIXDELAY = 8'h24;
    localparam logic [7:0] OFS_MODE     = 8'h28;
    localparam logic [7:0] OFS_CONFIG   = 8'h2c;
    localparam logic [7:0] OFS_FREQ     = 8'h30;
    localparam logic [7:0] OFS_LIMIT    = 8'h34;

    // Field positions.
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_OUTPUT_BIT = 1;
    localparam int CFG_FINE_BIT    = 0;
    localparam int CFG_HWEN_BIT    = 1;
    localparam int CFG_MAP_BIT     = 2;

    // Operation modes.
    typedef enum logic [3:0] {
        MODE_OFF        = 4'h0,
        MODE_PLC_PULSE  = 4'h3,
        MODE_PWM        = 4'h4
    } op_mode_t;

    // Pulse sequencer states, Gray coded along the usual path.
    typedef enum logic [1:0] {
        SEQ_IDLE  = 2'b00,
        SEQ_FIXED = 2'b01,
        SEQ_DELAY = 2'b11,
        SEQ_PULSE = 2'b10
    } seq_state_t;

endpackage : led_pkg

// ==== verilog/duty_limit_divider.sv ====
// Serial restoring divider that derives the duty-cycle ceiling.
// Assumes start is a one-cycle pulse and is not raised while busy.
`timescale 1ns/1ps
module duty_limit_divider #(
    parameter int NW = 26,
    parameter int DW = 16
) (
    // Clock, reset and enable.
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          ce,
    // Request.
    input  wire logic          start,
    input  wire logic [NW-1:0] dividend,
    input  wire logic [DW-1:0] divisor,
    // Answer.
    output logic               busy,
    output logic               done,
    output logic [NW-1:0]      quotient
);
    localparam int DIV_LATENCY = 27;

    logic [DW:0]         rem_reg;
    logic [DW-1:0]       div_reg;
    logic [5:0]          cnt_reg;
    logic [DW:0]         shifted;
    logic                fits;

    assign shifted = {rem_reg[DW-1:0], quotient[NW-1]};
    assign fits    = shifted >= {1'b0, div_reg};
    assign busy    = cnt_reg != 6'h00;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rem_reg  <= '0;
            div_reg  <= '0;
            cnt_reg  <= 6'h00;
            quotient <= '0;
            done     <= 1'b0;
        end
        else if (ce)
        begin
            done <= 1'b0;
            if (start)
            begin
                rem_reg  <= '0;
                div_reg  <= divisor;
                quotient <= dividend;
                cnt_reg  <= 6'(NW);
            end
            else if (busy)
            begin
                rem_reg  <= fits ? (shifted - {1'b0, div_reg}) : shifted;
                quotient <= {quotient[NW-2:0], fits};
                cnt_reg  <= cnt_reg - 6'h01;
                done     <= cnt_reg == 6'h01;
            end
        end
    end

    property p_div_done;
        @(posedge clk) disable iff (!rst_n)
        start |-> ##DIV_LATENCY done;
    endproperty
    a_div_done: assert property (p_div_done)
        else $error("Duty limit not ready on time.");

endmodule : duty_limit_divider

// ==== verilog/pulse_sequencer.sv ====
// Delay and pulse timer of the host-triggered pulse mode.
// Assumes fire is a one-cycle pulse; a fire while busy is ignored.
`timescale 1ns/1ps
module pulse_sequencer (
    // Clock, reset and enable.
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // Pulse request.
    input  wire logic        fire,
    input  wire logic        fine_res,
    input  wire logic [15:0] fixed_ticks,
    input  wire logic [15:0] delay_ticks,
    input  wire logic [15:0] length_ticks,
    // Status.
    output logic             busy,
    output logic             pulse_on
);
    led_pkg::seq_state_t state_reg;
    led_pkg::seq_state_t state_next;
    logic [15:0]         cnt_reg;
    logic [15:0]         cnt_next;
    logic [7:0]          pre_reg;
    logic [15:0]         len_reg;
    logic [15:0]         dly_reg;
    logic                fine_reg;
    logic [7:0]          pre_top;
    logic                tick;

    assign pre_top = (state_reg == led_pkg::SEQ_FIXED || fine_reg) ?
                     8'(led_pkg::FINE_CYC - 1) : 8'(led_pkg::US_CYC - 1);
    assign tick     = pre_reg == pre_top;
    assign busy     = state_reg != led_pkg::SEQ_IDLE;
    assign pulse_on = state_reg == led_pkg::SEQ_PULSE;

    always_comb
    begin
        state_next = state_reg;
        cnt_next   = tick ? cnt_reg - 16'h0001 : cnt_reg;
        case (state_reg)
            led_pkg::SEQ_IDLE:
            begin
                cnt_next = fixed_ticks;
                if (fire)
                    state_next = led_pkg::SEQ_FIXED;
            end
            led_pkg::SEQ_FIXED:
            begin
                if (cnt_reg == 16'h0000)
                begin
                    state_next = led_pkg::SEQ_DELAY;
                    cnt_next   = dly_reg;
                end
            end
            led_pkg::SEQ_DELAY:
            begin
                if (cnt_reg == 16'h0000)
                begin
                    state_next = (len_reg == 16'h0000) ?
                                 led_pkg::SEQ_IDLE : led_pkg::SEQ_PULSE;
                    cnt_next   = len_reg - 16'h0001;
                end
            end
            led_pkg::SEQ_PULSE:
            begin
                if (cnt_reg == 16'h0000 && tick)
                    state_next = led_pkg::SEQ_IDLE;
            end
            default:
                state_next = led_pkg::SEQ_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= led_pkg::SEQ_IDLE;
            cnt_reg   <= 16'h0000;
            pre_reg   <= 8'h00;
            len_reg   <= 16'h0000;
            dly_reg   <= 16'h0000;
            fine_reg  <= 1'b0;
        end
        else if (ce)
        begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            pre_reg   <= (tick || state_next != state_reg) ? 8'h00 :
                         pre_reg + 8'h01;
            if (!busy && fire)
            begin
                len_reg  <= length_ticks;
                dly_reg  <= delay_ticks;
                fine_reg <= fine_res;
            end
        end
    end

    property p_pulse_unit;
        @(posedge clk) disable iff (!rst_n)
        (pulse_on && !fine_reg && tick) |-> pre_reg == 8'(led_pkg::US_CYC - 1);
    endproperty
    a_pulse_unit: assert property (p_pulse_unit)
        else $error("Pulse time unit wrong.");

endmodule : pulse_sequencer

// ==== tb/host_master.sv ====
// Host model: APB master that drives the LED channel registers.
// Assumes the bench top calls its tasks and owns the closing report.
`timescale 1ns/1ps
module host_master (
    // Clock.
    input  wire logic        clk,
    // APB master side.
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    logic [31:0] rd;
    logic        er;
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
    end
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 50 && pready !== 1'b1; n++)
            @(posedge clk);
        rd = prdata;
        er = pslverr;
        if (n == 50)
            led_pulse_pwm_control_tb.test_done(1);
        psel    <= 1'b0;
        penable <= 1'b0;
        pwdata  <= ~d;
    endtask : apb
    task automatic arm(input logic [31:0] c);
        int n;
        for (n = 0; n < 100; n++)
        begin
            apb(1'b0, led_pkg::OFS_STATUS, 32'h0);
            if (rd[0] === 1'b1)
                break;
        end
        if (n == 100)
            led_pulse_pwm_control_tb.test_done(1);
        apb(1'b1, led_pkg::OFS_CONTROL, c);
    endtask : arm
endmodule : host_master

// ==== tb/led_pulse_pwm_control_tb.sv ====
// Bench top: checks pulse timing, PWM duty and limits of the LED channel.
// Assumes led_pkg and host_master are compiled first.
`timescale 1ns/1ps
module led_pulse_pwm_control_tb;
    logic        clk;
    logic        rst_n;
    logic        ce;
    logic        trig_in;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        led_drive;
    logic [15:0] cur;
    logic [15:0] volt;
    logic        dq;
    int          error_cnt;
    int          n_checks;
    int          cyc;
    int          rises;
    int          highs;
    int          rise_at;
    int          t;
    int          lim;
    int          du;
    int          v;
    int          h0;
    int          r0;
    int          lo;
    led_pulse_pwm_control led_pulse_pwm_control_i (
        .clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .trig_in(trig_in), .led_drive(led_drive),
        .led_current_ma(cur), .led_voltage_cv(volt));
    host_master h (
        .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (led_drive === 1'b1)
            highs <= highs + 1;
        if (led_drive === 1'b1 && !dq)
        begin
            rises   <= rises + 1;
            rise_at <= cyc;
        end
        dq <= (led_drive === 1'b1);
    end
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e)
        begin
            error_cnt++;
            $display("[ERR] %0t seen %h exp %h", $time, s, e);
        end
    endtask : check
    task automatic test_done(input int to);
        error_cnt += to;
        $display("TB: checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : test_done
    task automatic wr(input logic [7:0] a, input int d);
        h.apb(1'b1, a, d);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input int e);
        h.apb(1'b0, a, 32'h0);
        check(h.rd, e);
    endtask : rdc
    task automatic pulse(input int c, l, d, f, n);
        int u;
        int t0;
        int w;
        u = c[0] ? 13 : 125;
        w = f * 13 + d * u;
        wr(led_pkg::OFS_CONFIG, c);
        wr(led_pkg::OFS_LENGTH, l);
        wr(led_pkg::OFS_DELAY, d);
        wr(led_pkg::OFS_FIXDELAY, f);
        wr(led_pkg::OFS_CONTROL, 1);
        r0 = rises;
        h0 = highs;
        h.arm(3);
        t0 = cyc;
        repeat (w + l * u + 40) @(posedge clk);
        check(rises - r0, n);
        check(highs - h0, n * l * u);
        if (n > 0)
            check(rise_at - t0 >= w - 2 && rise_at - t0 <= w + 8, 1);
    endtask : pulse
    initial
    begin
        {rst_n, trig_in, dq, error_cnt, n_checks} = '0;
        ce = 1'b1;
        {cyc, rises, highs, rise_at} = '0;
        void'($urandom(81947));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rdc(led_pkg::OFS_FREQ, 1050);
        rdc(led_pkg::OFS_LIMIT, 32767);
        rdc(led_pkg::OFS_MODE, 0);
        rdc(8'h3c, 0);
        check(h.er, 1);
        $display("TB: reset test done");
        t = $urandom_range(4000, 1500);
        lim = 39320400 / t;
        wr(led_pkg::OFS_MODE, 4);
        wr(led_pkg::OFS_TARGET, t);
        h.arm(1);
        rdc(led_pkg::OFS_LIMIT, lim);
        du = $urandom_range(lim, 100);
        wr(led_pkg::OFS_DUTY, du);
        wr(led_pkg::OFS_DUTY, lim + 1);
        rdc(led_pkg::OFS_DUTY, du);
        wr(led_pkg::OFS_FREQ, 62500);
        v = $urandom_range(2400, 100);
        wr(led_pkg::OFS_OUTVOLT, v);
        h.arm(3);
        repeat (2000) @(posedge clk);
        h0 = highs;
        repeat (4000) @(posedge clk);
        lo = 2 * (du * 2000 / 32768);
        check(highs - h0 >= lo && highs - h0 <= lo + 2, 1);
        ce <= 1'b0;
        repeat (2) @(posedge clk);
        h0 = highs;
        r0 = led_drive;
        repeat (50) @(posedge clk);
        check(highs - h0, r0 * 50);
        ce <= 1'b1;
        check(32'(cur), t);
        check(32'(volt), v);
        wr(led_pkg::OFS_CURRENT, 700);
        wr(led_pkg::OFS_CONFIG, 4);
        repeat (4) @(posedge clk);
        check(32'(cur), 700);
        $display("TB: pwm test done");
        wr(led_pkg::OFS_MODE, 3);
        pulse(0, 2, 1, 2, 1);
        pulse(1, 5, 3, 0, 1);
        r0 = rises;
        h.arm(3);
        repeat (300) @(posedge clk);
        check(rises - r0, 0);
        pulse(2, 3, 0, 0, 0);
        trig_in <= 1'b1;
        pulse(2, 3, 0, 0, 1);
        $display("TB: pulse test done");
        test_done(0);
    end
endmodule : led_pulse_pwm_control_tb
